// ==== bench/sleep_wake_mode_controller_tb_top.sv ====
// Self-checking bench for the sleep/wake mode controller
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_mode_controller_tb_top;
  import swm_pkg::*;
  // ----------------------------------------
  // Stimulus, design and host model
  // ----------------------------------------
  localparam int IDLE = 5;
  localparam int WARN = 4;
  localparam int RCH = 20;
  localparam int TK = 0, CW = 1, PR = 2, RD = 3, FN = 4, BP = 5;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] pls = '0; // Pulse inputs, one bit each
  logic [31:0] now_time = 32'h0;
  logic reset_switch_in = 1'b0, alarm_set = 1'b0, beam_test_active = 1'b0, ambient_fail = 1'b0;
  logic [15:0] ambient_temp = 16'h0, attitude_temp = 16'h0;
  swm_fault_in_type fault_in = '0;
  logic break_in, host_char;
  swm_host_cmd_type host_cmd;
  logic asleep, collecting, measuring, prompt, deploy_warning, new_deployment, recharge_wake;
  logic [1:0] beam_sel;
  logic [15:0] water_temp;
  swm_fault_sum_type fault_sum;
  swm_fault_out_type fault_out;
  int err_count = 0;
  int total_checks = 0;

  // 10 MHz clock
  always #50 clock = ~clock;

  // Short timing figures keep the run small
  swm_controller #(.IDLE_SEC(IDLE), .WARN_SEC(WARN), .RECHARGE_SEC(RCH)) i_dut (
    .clock(clock), .reset_n(reset_n), .second_tick(pls[TK]), .now_time(now_time),
    .break_in(break_in), .reset_switch_in(reset_switch_in), .cold_wake(pls[CW]),
    .power_restored(pls[PR]), .recharge_done(pls[RD]), .alarm_set(alarm_set),
    .host_cmd(host_cmd), .host_char(host_char), .fault_in(fault_in), .fault_rd_next(pls[FN]),
    .beam_test_active(beam_test_active), .beam_pass(pls[BP]), .ambient_fail(ambient_fail),
    .ambient_temp(ambient_temp), .attitude_temp(attitude_temp), .asleep(asleep),
    .collecting(collecting), .measuring(measuring), .prompt(prompt),
    .deploy_warning(deploy_warning), .new_deployment(new_deployment),
    .recharge_wake(recharge_wake), .beam_sel(beam_sel), .water_temp(water_temp),
    .fault_sum(fault_sum), .fault_out(fault_out));

  swm_host_model i_host (.clock(clock), .break_in(break_in), .host_cmd(host_cmd), .host_char(host_char));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Look just after an edge so its updates have landed
  task automatic look(input int n);
    cyc(n);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pulse(input int k);
    cyc(1);
    pls[k] <= 1'b1;
    cyc(1);
    pls[k] <= 1'b0;
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) pulse(TK);
  endtask

  // Switch held a few cycles; the synchroniser only wants the edge
  task automatic press();
    cyc(1);
    reset_switch_in <= 1'b1;
    cyc(3);
    reset_switch_in <= 1'b0;
    #1;
  endtask

  task automatic fault(input logic [31:0] t, input logic [15:0] c, input logic [31:0] p);
    cyc(1);
    now_time <= t;
    fault_in <= '{1'b1, c, p};
    cyc(1);
    fault_in <= '{1'b0, ~c, ~p};
  endtask

  task automatic rst();
    cyc(1);
    reset_n <= 1'b0;
    now_time <= 32'h64;
    alarm_set <= 1'b0;
    ambient_fail <= 1'b0;
    beam_test_active <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    look(1);
  endtask

  // Sleep long enough for the capacitor wake, then finish charging
  task automatic recharge();
    tick(RCH - 2);
    chk(recharge_wake, 1'b0);
    for (int i = 0; i < 6 && recharge_wake !== 1'b1; i++) tick(1);
    chk(recharge_wake, 1'b1);
    pulse(RD);
    look(1);
    chk({asleep, recharge_wake}, 2'h2);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_command();
    rst();
    chk({asleep, collecting, measuring, prompt}, 4'h8);
    pulse(CW);
    chk({asleep, prompt}, 2'h1);
    tick(IDLE - 1);
    i_host.send_char();
    tick(IDLE - 1);
    chk(asleep, 1'b0);
    tick(3);
    chk(asleep, 1'b1);
    pulse(CW);
    tick(3);
    i_host.send_break();
    tick(IDLE - 1);
    chk({asleep, prompt}, 2'h1);
    press();
    for (int i = 0; i < 8 && asleep !== 1'b1; i++) look(1);
    chk(asleep, 1'b1);
    recharge();
    chk(collecting, 1'b0);
    $display("t_command done");
  endtask

  task automatic t_collect();
    rst();
    pulse(CW);
    i_host.send_cmd(SWM_CMD_START, 32'h0);
    #1;
    chk({collecting, measuring, new_deployment}, 3'h7);
    look(1);
    chk(new_deployment, 1'b0);
    i_host.send_break();
    for (int i = 0; i < 8 && prompt !== 1'b1; i++) look(1);
    chk({collecting, prompt}, 2'h3);
    tick(WARN - 1);
    chk(deploy_warning, 1'b0);
    tick(1);
    look(1);
    chk(deploy_warning, 1'b1);
    tick(IDLE - WARN);
    look(2);
    chk({collecting, measuring, prompt}, 3'h6);
    press();
    for (int i = 0; i < 8 && new_deployment !== 1'b1; i++) look(1);
    chk({new_deployment, measuring}, 2'h3);
    // Cold wake and power return are only seen while asleep, so sleep on an alarm first
    cyc(1);
    alarm_set <= 1'b1;
    press();
    for (int i = 0; i < 8 && asleep !== 1'b1; i++) look(1);
    chk({asleep, measuring}, 2'h2);
    pulse(CW);
    chk({new_deployment, measuring, asleep}, 3'h6);
    press();
    for (int i = 0; i < 8 && asleep !== 1'b1; i++) look(1);
    chk(asleep, 1'b1);
    pulse(PR);
    look(1);
    chk({collecting, measuring, asleep}, 3'h6);
    i_host.send_break();
    for (int i = 0; i < 8 && prompt !== 1'b1; i++) look(1);
    i_host.send_cmd(SWM_CMD_OTHER, 32'h0);
    #1;
    chk(collecting, 1'b0);
    $display("t_collect done");
  endtask

  task automatic t_first();
    rst();
    pulse(CW);
    i_host.send_cmd(SWM_CMD_FIRST_TIME, 32'h6e);
    i_host.send_cmd(SWM_CMD_START, 32'h0);
    look(1);
    chk({asleep, measuring}, 2'h2);
    cyc(1);
    now_time <= 32'h6e;
    for (int i = 0; i < 8 && measuring !== 1'b1; i++) look(1);
    chk({asleep, measuring, collecting}, 3'h3);
    cyc(1);
    alarm_set <= 1'b1;
    press();
    for (int i = 0; i < 8 && asleep !== 1'b1; i++) look(1);
    chk(asleep, 1'b1);
    recharge();
    $display("t_first done");
  endtask

  task automatic t_fault();
    rst();
    pulse(CW);
    fault(32'h32, 16'h0a08, 32'h0);
    fault(32'h3c, 16'h0a16, 32'h5);
    fault(32'h3c, 16'h0a08, 32'h0);
    look(1);
    chk(fault_sum.unique_faults, 16'h2);
    chk(fault_sum.first_time, 32'h32);
    chk(fault_sum.last_time, 32'h3c);
    i_host.send_cmd(SWM_CMD_FAULT_DISPLAY, 32'h0);
    pulse(FN);
    chk(fault_out.valid, 1'b1);
    chk({fault_out.code, fault_out.count}, 32'h0a08_0002);
    chk(fault_out.delta, 32'ha);
    chk(fault_out.time_stamp, 32'h3c);
    pulse(FN);
    chk({fault_out.code, fault_out.count}, 32'h0a16_0001);
    chk(fault_out.param, 32'h5);
    // Seven more distinct codes fill the log and spill one into the overflow count
    for (int i = 0; i < 7; i++) fault(32'h46, 16'h0b00 + 16'(i), 32'h0);
    look(1);
    chk({fault_sum.unique_faults, fault_sum.overflow}, 32'h0008_0001);
    i_host.send_cmd(SWM_CMD_FAULT_CLEAR, 32'h0);
    look(1);
    chk({fault_sum.unique_faults, fault_sum.overflow}, 32'h0);
    $display("t_fault done");
  endtask

  task automatic t_misc();
    rst();
    pulse(CW);
    cyc(1);
    ambient_temp <= 16'h1111;
    attitude_temp <= 16'h2222;
    look(2);
    chk(water_temp, 16'h1111);
    cyc(1);
    ambient_fail <= 1'b1;
    look(2);
    chk(water_temp, 16'h2222);
    cyc(1);
    beam_test_active <= 1'b1;
    look(1);
    chk(beam_sel, 2'h0);
    i_host.send_char();
    i_host.send_char();
    look(1);
    chk(beam_sel, 2'h2);
    pulse(BP);
    chk(beam_sel, 2'h3);
    i_host.send_char();
    look(1);
    chk(beam_sel, 2'h3);
    $display("t_misc done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reset held eight cycles, then each scenario in turn
  initial begin
    cyc(8);
    reset_n <= 1'b1;
    t_command();
    t_collect();
    t_first();
    t_fault();
    t_misc();
    tally_and_finish();
  end

  // The scenarios need well under a thousand cycles; allow ten times that
  initial begin
    #1000000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== bench/swm_host_model.sv ====
// Host terminal model: serial break, decoded commands and characters
`timescale 1ns/1ps
`default_nettype none
module swm_host_model (
  input wire logic clock, // Bench clock
  output var logic break_in, // Serial break level
  output var swm_pkg::swm_host_cmd_type host_cmd, // Decoded host command
  output var logic host_char // One pulse per character
);
  import swm_pkg::*;

  // Idle line at time zero
  initial begin
    break_in = 1'b0;
    host_cmd = '0;
    host_char = 1'b0;
  end

  // Break held four cycles so the pin synchroniser sees a clean edge
  task automatic send_break();
    @(posedge clock);
    break_in <= 1'b1;
    repeat (4) @(posedge clock);
    break_in <= 1'b0;
  endtask

  // One command, valid for one cycle; stale fields are scrambled afterwards
  task automatic send_cmd(input swm_cmd_type c, input logic [31:0] a);
    @(posedge clock);
    host_cmd <= '{valid: 1'b1, cmd: c, arg: a};
    @(posedge clock);
    host_cmd <= '{valid: 1'b0, cmd: SWM_CMD_OTHER, arg: ~a};
  endtask

  // Any character; during the beam test it steps to the next beam
  task automatic send_char();
    @(posedge clock);
    host_char <= 1'b1;
    @(posedge clock);
    host_char <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== common/swm_map.svh ====
// Constants for the sleep/wake mode controller
`ifndef SWM_MAP_SVH
`define SWM_MAP_SVH
// Timekeeping tick rate and durations (seconds per tick = 1)
`define SWM_CLOCK_HZ 10000000
`define SWM_IDLE_MIN 5
`define SWM_WARN_MIN 4
`define SWM_RECHARGE_HOURS 9
`define SWM_SECONDS_PER_MIN 60
`define SWM_SECONDS_PER_HOUR 3600
`define SWM_IDLE_SEC (`SWM_IDLE_MIN * `SWM_SECONDS_PER_MIN)
`define SWM_WARN_SEC (`SWM_WARN_MIN * `SWM_SECONDS_PER_MIN)
`define SWM_RECHARGE_SEC (`SWM_RECHARGE_HOURS * `SWM_SECONDS_PER_HOUR)
// Fault log layout
`define SWM_FAULT_DEPTH 8
`define SWM_FAULT_CODE_W 16
`define SWM_FAULT_TIME_W 32
`define SWM_FAULT_PARAM_W 32
`define SWM_FAULT_CNT_W 16
`endif

// ==== common/swm_pkg.sv ====
// Types for the sleep/wake mode controller
`default_nettype none
package swm_pkg;
  typedef enum logic [2:0] {
    SWM_CMD_NONE,
    SWM_CMD_START,
    SWM_CMD_FIRST_TIME,
    SWM_CMD_FAULT_DISPLAY,
    SWM_CMD_FAULT_CLEAR,
    SWM_CMD_OTHER
  } swm_cmd_type;

  typedef struct packed {
    logic valid;
    swm_cmd_type cmd;
    logic [31:0] arg;
  } swm_host_cmd_type;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
    logic [31:0] param;
  } swm_fault_in_type;

  typedef struct packed {
    logic valid;
    logic [7:0] index;
    logic [15:0] code;
    logic [15:0] count;
    logic [31:0] delta;
    logic [31:0] time_stamp;
    logic [31:0] param;
  } swm_fault_out_type;

  typedef struct packed {
    logic [15:0] unique_faults;
    logic [15:0] overflow;
    logic [31:0] first_time;
    logic [31:0] last_time;
  } swm_fault_sum_type;
endpackage
`default_nettype wire

// ==== hw/swm_controller.sv ====
// Sleep, command and collecting mode controller with fault log and sensor fallbacks
// Overview of operation
// - Command state idle over 5 minutes sends device to sleep.
// - Break in command state shows prompt and waits for a command.
// - Reset switch in command state puts device to sleep.
// - Start command begins collecting, or sleeps until first-measurement time.
// - Cold wakeup in command state goes to the command prompt.
// - Nine hour sleep wakes to recharge; command state resleeps afterward.
// - Collecting state survives power loss with configuration kept.
// - Break while collecting prompts but stays collecting until valid command.
// - Silent break while collecting warns at four minutes, resumes at five.
// - Reset while collecting: sleep on alarm, else new deployment or wait.
// - Cold wakeup while collecting: new deployment, or wait for future time.
// - Recharge while collecting: sleep on alarm, else resume or wait.
// - Fault log keeps unique faults, overflow, times; display and clear.
// - Failed ambient sensor is replaced by attitude temperature.
// - During beam test any host character advances to the next beam.
`timescale 1ns/1ps
`default_nettype none
`include "swm_map.svh"
module swm_controller #(
  parameter int unsigned FAULT_DEPTH = `SWM_FAULT_DEPTH,
  parameter int unsigned IDLE_SEC = `SWM_IDLE_SEC,
  parameter int unsigned WARN_SEC = `SWM_WARN_SEC,
  parameter int unsigned RECHARGE_SEC = `SWM_RECHARGE_SEC,
  parameter int unsigned BEAMS = 4
) (
  input wire logic clock, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic second_tick, // One-cycle pulse per timekeeping second
  input wire logic [31:0] now_time, // Current real time
  input wire logic break_in, // Serial break pin, async
  input wire logic reset_switch_in, // Reset switch pin, async
  input wire logic cold_wake, // Pulse: cold wakeup from unknown state
  input wire logic power_restored, // Pulse: power returned after loss
  input wire logic recharge_done, // Pulse: RAM capacitor charged
  input wire logic alarm_set, // Next-measurement alarm valid
  input wire swm_pkg::swm_host_cmd_type host_cmd, // Decoded host command
  input wire logic host_char, // Pulse: any host character
  input wire swm_pkg::swm_fault_in_type fault_in, // Fault report
  input wire logic fault_rd_next, // Pulse: step fault display
  input wire logic beam_test_active, // Beam continuity test running
  input wire logic beam_pass, // Pulse: current beam passed
  input wire logic ambient_fail, // Ambient sensor failed
  input wire logic [15:0] ambient_temp, // Ambient temperature
  input wire logic [15:0] attitude_temp, // Attitude temperature
  output logic asleep, // Device sleeping
  output logic collecting, // In data-collecting state
  output logic measuring, // Measurements running
  output logic prompt, // Command prompt shown
  output logic deploy_warning, // Self-deploy warning shown
  output logic new_deployment, // Pulse: new deployment started
  output logic recharge_wake, // Awake to recharge RAM capacitor
  output logic [1:0] beam_sel, // Beam under test
  output logic [15:0] water_temp, // Temperature in use
  output swm_pkg::swm_fault_sum_type fault_sum, // Fault log summary
  output swm_pkg::swm_fault_out_type fault_out // Fault log entry on display
);
  import swm_pkg::*;

  typedef enum logic [1:0] {SWM_SLEEP, SWM_AWAKE, SWM_WAIT_TIME, SWM_RECHARGE} swm_state_type;

  localparam int unsigned IDX_W = $clog2(FAULT_DEPTH);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Three stages; a level counts once the second and third agree
  logic [2:0] brk_sync_q, rst_sync_q;
  logic brk_lvl_q, rst_lvl_q;
  logic [2:0] brk_sync_d, rst_sync_d;
  logic brk_lvl_d, rst_lvl_d;
  logic break_ev, reset_ev;

  always_comb begin
    brk_sync_d = {brk_sync_q[1:0], break_in};
    rst_sync_d = {rst_sync_q[1:0], reset_switch_in};
    brk_lvl_d = (brk_sync_q[1] == brk_sync_q[2]) ? brk_sync_q[2] : brk_lvl_q;
    rst_lvl_d = (rst_sync_q[1] == rst_sync_q[2]) ? rst_sync_q[2] : rst_lvl_q;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      brk_sync_q <= 3'h0;
      rst_sync_q <= 3'h0;
      brk_lvl_q <= 1'b0;
      rst_lvl_q <= 1'b0;
    end else begin
      brk_sync_q <= brk_sync_d;
      rst_sync_q <= rst_sync_d;
      brk_lvl_q <= brk_lvl_d;
      rst_lvl_q <= rst_lvl_d;
    end
  end

  assign break_ev = brk_lvl_d & ~brk_lvl_q;
  assign reset_ev = rst_lvl_d & ~rst_lvl_q;

  // ---------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------
  // Mode flags are in retained RAM, so power loss leaves them as they were
  swm_state_type state_q, state_d;
  logic collect_q, collect_d; // Ping-mode flag
  logic measure_q, measure_d;
  logic prompt_q, prompt_d;
  logic warn_q, warn_d;
  logic tf_set_q, tf_set_d; // First-measurement time set since last break
  logic [31:0] tf_time_q, tf_time_d;
  logic [31:0] idle_q, idle_d; // Seconds without host input
  logic [31:0] sleep_q, sleep_d; // Seconds asleep
  logic newdep_q, newdep_d;
  logic valid_cmd;
  logic tf_valid;

  assign valid_cmd = host_cmd.valid && host_cmd.cmd != SWM_CMD_NONE;
  assign tf_valid = tf_set_q && (tf_time_q >= now_time);

  always_comb begin
    state_d = state_q;
    collect_d = collect_q;
    measure_d = measure_q;
    prompt_d = prompt_q;
    warn_d = warn_q;
    tf_set_d = tf_set_q;
    tf_time_d = tf_time_q;
    newdep_d = 1'b0;
    idle_d = (second_tick && idle_q != 32'hffffffff) ? idle_q + 32'h1 : idle_q;
    // Sleep time restarts on every wake, so short naps never add up to a recharge
    sleep_d = (state_q != SWM_SLEEP) ? 32'h0 : (second_tick ? sleep_q + 32'h1 : sleep_q);
    if (valid_cmd || host_char) begin
      idle_d = 32'h0;
    end
    if (host_cmd.valid && host_cmd.cmd == SWM_CMD_FIRST_TIME) begin
      tf_set_d = 1'b1;
      tf_time_d = host_cmd.arg;
    end
    unique case (state_q)
      SWM_SLEEP: begin
        if (break_ev) begin
          state_d = SWM_AWAKE;
          prompt_d = 1'b1;
          measure_d = 1'b0;
          tf_set_d = 1'b0;
          idle_d = 32'h0;
        end else if (cold_wake) begin
          state_d = SWM_AWAKE;
          idle_d = 32'h0;
          if (!collect_q) begin
            prompt_d = 1'b1;
          end else if (tf_valid) begin
            state_d = SWM_WAIT_TIME;
          end else begin
            measure_d = 1'b1;
            newdep_d = 1'b1;
          end
        end else if (sleep_q >= RECHARGE_SEC) begin
          state_d = SWM_RECHARGE;
          sleep_d = 32'h0;
        end else if (power_restored && collect_q) begin
          state_d = SWM_AWAKE;
          measure_d = 1'b1;
        end
      end
      SWM_AWAKE: begin
        if (reset_ev) begin
          prompt_d = 1'b0;
          warn_d = 1'b0;
          if (!collect_q) begin
            state_d = SWM_SLEEP;
          end else if (alarm_set) begin
            state_d = SWM_SLEEP;
            measure_d = 1'b0;
          end else if (tf_set_q) begin
            state_d = SWM_WAIT_TIME;
            measure_d = 1'b0;
          end else begin
            measure_d = 1'b1;
            newdep_d = 1'b1;
          end
        end else if (break_ev) begin
          prompt_d = 1'b1;
          measure_d = 1'b0;
          warn_d = 1'b0;
          tf_set_d = 1'b0;
          idle_d = 32'h0;
        end else if (host_cmd.valid && host_cmd.cmd == SWM_CMD_START) begin
          collect_d = 1'b1;
          prompt_d = 1'b0;
          if (tf_set_q) begin
            state_d = SWM_WAIT_TIME;
          end else begin
            measure_d = 1'b1;
            newdep_d = 1'b1;
          end
        end else if (valid_cmd && prompt_q) begin
          collect_d = 1'b0;
          warn_d = 1'b0;
        end else if (prompt_q && collect_q) begin
          if (idle_q >= IDLE_SEC) begin
            prompt_d = 1'b0;
            warn_d = 1'b0;
            measure_d = 1'b1;
          end else if (idle_q >= WARN_SEC) begin
            warn_d = 1'b1;
          end
        end else if (!collect_q && idle_q >= IDLE_SEC) begin
          state_d = SWM_SLEEP;
          prompt_d = 1'b0;
        end
      end
      SWM_WAIT_TIME: begin
        if (break_ev) begin
          state_d = SWM_AWAKE;
          prompt_d = 1'b1;
          tf_set_d = 1'b0;
          idle_d = 32'h0;
        end else if (now_time >= tf_time_q) begin
          state_d = SWM_AWAKE;
          measure_d = 1'b1;
          newdep_d = 1'b1;
          tf_set_d = 1'b0;
        end
      end
      SWM_RECHARGE: begin
        if (recharge_done) begin
          if (!collect_q || alarm_set) begin
            state_d = SWM_SLEEP;
          end else if (tf_valid) begin
            state_d = SWM_WAIT_TIME;
          end else begin
            state_d = SWM_AWAKE;
            measure_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SWM_SLEEP;
      collect_q <= 1'b0;
      measure_q <= 1'b0;
      prompt_q <= 1'b0;
      warn_q <= 1'b0;
      tf_set_q <= 1'b0;
      tf_time_q <= 32'h0;
      idle_q <= 32'h0;
      sleep_q <= 32'h0;
      newdep_q <= 1'b0;
    end else begin
      state_q <= state_d;
      collect_q <= collect_d;
      measure_q <= measure_d;
      prompt_q <= prompt_d;
      warn_q <= warn_d;
      tf_set_q <= tf_set_d;
      tf_time_q <= tf_time_d;
      idle_q <= idle_d;
      sleep_q <= sleep_d;
      newdep_q <= newdep_d;
    end
  end

  assign asleep = (state_q == SWM_SLEEP) || (state_q == SWM_WAIT_TIME);
  assign collecting = collect_q;
  assign measuring = measure_q;
  assign prompt = prompt_q;
  assign deploy_warning = warn_q;
  assign new_deployment = newdep_q;
  assign recharge_wake = (state_q == SWM_RECHARGE);

  // ---------------------------------------------------------------
  // Beam test stepping and temperature fallback
  // ---------------------------------------------------------------
  // Any character skips a failing beam so the operator is never stuck
  logic [1:0] beam_q, beam_d;
  logic [15:0] temp_q, temp_d;

  always_comb begin
    beam_d = beam_q;
    if (!beam_test_active) begin
      beam_d = 2'h0;
    end else if ((beam_pass || host_char) && beam_q != 2'(BEAMS - 1)) begin
      beam_d = beam_q + 2'h1;
    end
    temp_d = ambient_fail ? attitude_temp : ambient_temp;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      beam_q <= 2'h0;
      temp_q <= 16'h0;
    end else begin
      beam_q <= beam_d;
      temp_q <= temp_d;
    end
  end

  assign beam_sel = beam_q;
  assign water_temp = temp_q;

  // ---------------------------------------------------------------
  // Fault log
  // ---------------------------------------------------------------
  // Duplicate codes bump the count; a full log counts overflow
  logic [15:0] f_code_q [FAULT_DEPTH];
  logic [15:0] f_cnt_q [FAULT_DEPTH];
  logic [31:0] f_time_q [FAULT_DEPTH];
  logic [31:0] f_delta_q [FAULT_DEPTH];
  logic [31:0] f_param_q [FAULT_DEPTH];
  logic [IDX_W:0] f_used_q;
  swm_fault_sum_type sum_q, sum_d;
  swm_fault_out_type out_q, out_d;
  logic [IDX_W:0] rd_q, rd_d;
  logic hit;
  logic [IDX_W-1:0] hit_idx;

  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < FAULT_DEPTH; i++) begin
      if (!hit && (IDX_W + 1)'(i) < f_used_q && f_code_q[i] == fault_in.code) begin
        hit = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end

  always_comb begin
    sum_d = sum_q;
    rd_d = rd_q;
    out_d = out_q;
    out_d.valid = 1'b0;
    if (host_cmd.valid && host_cmd.cmd == SWM_CMD_FAULT_CLEAR) begin
      sum_d = '0;
      rd_d = '0;
    end else if (fault_in.valid) begin
      if (sum_q.unique_faults == 16'h0) begin
        sum_d.first_time = now_time;
      end
      sum_d.last_time = now_time;
      if (!hit && f_used_q == (IDX_W + 1)'(FAULT_DEPTH)) begin
        sum_d.overflow = sum_q.overflow + 16'h1;
      end else if (!hit) begin
        sum_d.unique_faults = sum_q.unique_faults + 16'h1;
      end
    end
    if (host_cmd.valid && host_cmd.cmd == SWM_CMD_FAULT_DISPLAY) begin
      rd_d = '0;
    end else if (fault_rd_next && rd_q < f_used_q) begin
      out_d.valid = 1'b1;
      out_d.index = 8'(rd_q);
      out_d.code = f_code_q[rd_q[IDX_W-1:0]];
      out_d.count = f_cnt_q[rd_q[IDX_W-1:0]];
      out_d.delta = f_delta_q[rd_q[IDX_W-1:0]];
      out_d.time_stamp = f_time_q[rd_q[IDX_W-1:0]];
      out_d.param = f_param_q[rd_q[IDX_W-1:0]];
      rd_d = rd_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sum_q <= '0;
      out_q <= '0;
      rd_q <= '0;
      f_used_q <= '0;
    end else begin
      sum_q <= sum_d;
      out_q <= out_d;
      rd_q <= rd_d;
      if (host_cmd.valid && host_cmd.cmd == SWM_CMD_FAULT_CLEAR) begin
        f_used_q <= '0;
      end else if (fault_in.valid && hit) begin
        f_cnt_q[hit_idx] <= f_cnt_q[hit_idx] + 16'h1;
        f_delta_q[hit_idx] <= now_time - f_time_q[hit_idx];
        f_time_q[hit_idx] <= now_time;
        f_param_q[hit_idx] <= fault_in.param;
      end else if (fault_in.valid && f_used_q < (IDX_W + 1)'(FAULT_DEPTH)) begin
        f_code_q[f_used_q[IDX_W-1:0]] <= fault_in.code;
        f_cnt_q[f_used_q[IDX_W-1:0]] <= 16'h1;
        f_delta_q[f_used_q[IDX_W-1:0]] <= 32'h0;
        f_time_q[f_used_q[IDX_W-1:0]] <= now_time;
        f_param_q[f_used_q[IDX_W-1:0]] <= fault_in.param;
        f_used_q <= f_used_q + 1'b1;
      end
    end
  end

  assign fault_sum = sum_q;
  assign fault_out = out_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_idle_sleep: assert property (state_q == SWM_AWAKE && !collect_q && idle_q >= IDLE_SEC && !reset_ev && !break_ev
    && !host_cmd.valid |=> state_q == SWM_SLEEP) else $error("idle command state did not sleep");
  a_break_prompt: assert property (state_q == SWM_AWAKE && break_ev && !reset_ev |=> prompt_q && !measure_q)
    else $error("break did not prompt");
  a_reset_sleep: assert property (state_q == SWM_AWAKE && !collect_q && reset_ev |=> state_q == SWM_SLEEP)
    else $error("reset switch did not sleep");
  a_start_collect: assert property (state_q == SWM_AWAKE && !reset_ev && !break_ev && host_cmd.valid
    && host_cmd.cmd == SWM_CMD_START |=> collect_q) else $error("start did not collect");
  a_warn_before: assert property ($rose(warn_q) |-> collect_q && prompt_q && $past(idle_q) >= WARN_SEC)
    else $error("warning without cause");
  a_clear_log: assert property (host_cmd.valid && host_cmd.cmd == SWM_CMD_FAULT_CLEAR
    |=> sum_q == '0 && f_used_q == '0)
    else $error("fault log not cleared");
  a_temp_fallback: assert property (ambient_fail |=> water_temp == $past(attitude_temp))
    else $error("fallback temperature wrong");
  a_beam_step: assert property (beam_test_active && host_char && beam_q != 2'(BEAMS - 1)
    |=> beam_q == $past(beam_q) + 2'h1)
    else $error("beam did not advance");
  a_idle_restart: assert property (host_char |=> idle_q == 32'h0) else $error("idle count not restarted");

  c_deploy: cover property (newdep_q);
  c_warn: cover property (warn_q);
  c_recharge: cover property (state_q == SWM_RECHARGE ##[1:5] state_q == SWM_SLEEP);
  c_overflow: cover property (sum_q.overflow != 16'h0);
endmodule
`default_nettype wire
